// *** dlt_top.sv ***
// dlt_top: dual window limit checker with digital output lines, axi4-lite slave
// assumes readings, idle and trigger strobes are synchronous one-cycle pulses on aclk
// Function
// - first test keeps upper and lower bound, 33-bit signed, reset +1 and -1
// - second test keeps upper and lower bound, same range, reset +2 and -2
// - each test has its own enable bit
// - fail flag 1 once a reading reaches or passes either bound, else 0
// - fail flag hides which bound; event register shows high and low hits
// - auto clear, on after reset, clears fail on idle entry; clear command too
// - without auto clear a fail stays until the clear command
// - polarity select, active high after reset
// - global output enable, off after reset, forces lines inactive
// - pulse mode off after reset; duration 1 to 99999999 ms, default 2 ms
// - master latch enable off after reset
// - panel limit off strobe disables both tests together
// - first test off and second on: indicators follow the second test
// - every completed reading is checked while any test is enabled
// - a hit drives its line high, or low under active low polarity
// - pulse mode pulses once per failing reading; in-limit reading ends pulse
// - master line on any hit; unlatched releases in limits, latched until restart
// - lines: 1 low first, 2 high first, 3 low second, 4 high second, 5 master
`timescale 1ns/1ps
`default_nettype none
module dlt_top #(
  parameter int TICK_CYCLES = dlt_pkg::MS_TICK_CYCLES
) (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // axi4-lite write
  input  wire logic [7:0]              awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  // axi4-lite read
  input  wire logic [7:0]              araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // measurement side
  input  wire logic                    rd_valid,
  input  wire logic [dlt_pkg::BW-1:0]  rd_value,
  input  wire logic                    idle_entry,
  input  wire logic                    trig_restart,
  input  wire logic                    panel_limit_off,
  // lines and indicators
  output logic [4:0]                   out_lines,
  output logic                         ind_high,
  output logic                         ind_in,
  output logic                         ind_low,
  output logic                         second_test_inside_message
);
  dlt_pulse_if pif ();

  logic                   aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
  logic [7:0]             aw_addr_ff, nxt_aw_addr;
  logic [31:0]            w_data_ff, nxt_w_data;
  logic [3:0]             w_strb_ff, nxt_w_strb;
  logic                   bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [1:0]             bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0]            rdata_ff, nxt_rdata;
  logic [7:0]             ctrl_ff, nxt_ctrl;
  logic [dlt_pkg::PW-1:0] pulse_ms_ff, nxt_pulse_ms;
  logic [dlt_pkg::BW-1:0] bound_ff [4];
  logic [dlt_pkg::BW-1:0] nxt_bound [4];
  logic [1:0]             clr;
  logic [3:0]             hit, hit_m, hit_ff, nxt_hit;
  logic [1:0]             fail_ff, nxt_fail, fail_set;
  logic                   master_ff, nxt_master, pulse_on_ff, nxt_pulse_on;
  logic [4:0]             lines_ff, nxt_lines, lvl;
  logic                   eval, any_now, do_wr, oe_nxt, pol_nxt;
  logic [7:0]             waddr;
  logic [31:0]            wd, wmask, status;

  // byte lanes of a write merged over the old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [dlt_pkg::BW-1:0] b;
    b = bound_ff[a[4:3] - 2'h2];
    rd_mux = '0;
    if (a == dlt_pkg::OFS_CTRL) rd_mux = {24'h000000, ctrl_ff};
    else if (a == dlt_pkg::OFS_STATUS) rd_mux = status;
    else if (a == dlt_pkg::OFS_PULSE) rd_mux = {5'h00, pulse_ms_ff};
    else if (a == dlt_pkg::OFS_EVENT) rd_mux = {28'h0000000, hit_ff};
    else if (a >= dlt_pkg::OFS_BOUND && a <= dlt_pkg::OFS_BLAST) begin
      rd_mux = a[2] ? {31'h00000000, b[32]} : b[31:0];
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && (a <= dlt_pkg::OFS_BLAST || a == dlt_pkg::OFS_EVENT);
  endfunction

  // axi4-lite slave: address and data taken in either order, one response after both
  assign awready = !aw_got_ff && !bvalid_ff;
  assign wready  = !w_got_ff && !bvalid_ff;
  assign arready = !rvalid_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign rvalid  = rvalid_ff;
  assign rresp   = rresp_ff;
  assign rdata   = rdata_ff;

  always_comb begin
    nxt_aw_got  = aw_got_ff || (awvalid && awready);
    nxt_aw_addr = (awvalid && awready) ? awaddr : aw_addr_ff;
    nxt_w_got   = w_got_ff || (wvalid && wready);
    nxt_w_data  = (wvalid && wready) ? wdata : w_data_ff;
    nxt_w_strb  = (wvalid && wready) ? wstrb : w_strb_ff;
    waddr       = nxt_aw_addr;
    wd          = nxt_w_data;
    do_wr       = nxt_aw_got && nxt_w_got && !bvalid_ff;
    nxt_bvalid  = bvalid_ff && !bready;
    nxt_bresp   = bresp_ff;
    if (do_wr) begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = mapped(waddr) ? dlt_pkg::RESP_OKAY : dlt_pkg::RESP_SLVERR;
    end
    nxt_rvalid = rvalid_ff && !rready;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (arvalid && arready) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = mapped(araddr) ? rd_mux(araddr) : 32'h00000000;
      nxt_rresp  = mapped(araddr) ? dlt_pkg::RESP_OKAY : dlt_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff  <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_got_ff   <= 1'b0;
      w_data_ff  <= 32'h00000000;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= 2'h0;
    end else begin
      aw_got_ff  <= nxt_aw_got;
      aw_addr_ff <= nxt_aw_addr;
      w_got_ff   <= nxt_w_got;
      w_data_ff  <= nxt_w_data;
      w_strb_ff  <= nxt_w_strb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  // configuration registers
  always_comb begin
    nxt_ctrl     = ctrl_ff;
    nxt_pulse_ms = pulse_ms_ff;
    nxt_bound    = bound_ff;
    clr          = 2'h0;
    wmask        = 32'h00000000;
    if (do_wr) begin
      if (waddr == dlt_pkg::OFS_CTRL) begin
        wmask    = merge({24'h000000, ctrl_ff}, wd, nxt_w_strb);
        nxt_ctrl = wmask[7:0];
      end else if (waddr == dlt_pkg::OFS_CLEAR && nxt_w_strb[0]) begin
        clr = wd[1:0];
      end else if (waddr == dlt_pkg::OFS_PULSE) begin
        wmask = merge({5'h00, pulse_ms_ff}, wd, nxt_w_strb);
        // out-of-range durations are clamped rather than refused
        if (wmask[31:dlt_pkg::PW] != '0 || wmask[dlt_pkg::PW-1:0] > dlt_pkg::PULSE_MS_MAX) begin
          nxt_pulse_ms = dlt_pkg::PULSE_MS_MAX;
        end else if (wmask[dlt_pkg::PW-1:0] == '0) begin
          nxt_pulse_ms = dlt_pkg::PULSE_MS_MIN;
        end else begin
          nxt_pulse_ms = wmask[dlt_pkg::PW-1:0];
        end
      end else if (waddr >= dlt_pkg::OFS_BOUND && waddr <= dlt_pkg::OFS_BLAST) begin
        if (waddr[2]) begin
          if (nxt_w_strb[0]) nxt_bound[waddr[4:3] - 2'h2][32] = wd[0];
        end else begin
          wmask = merge(bound_ff[waddr[4:3] - 2'h2][31:0], wd, nxt_w_strb);
          nxt_bound[waddr[4:3] - 2'h2][31:0] = wmask;
        end
        // the one code below the signed range is pulled back to its minimum
        if (nxt_bound[waddr[4:3] - 2'h2] == 33'h100000000) begin
          nxt_bound[waddr[4:3] - 2'h2] = dlt_pkg::BOUND_MIN;
        end
      end
    end
    if (panel_limit_off) begin
      nxt_ctrl[dlt_pkg::CTL_EN1] = 1'b0;
      nxt_ctrl[dlt_pkg::CTL_EN2] = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff     <= dlt_pkg::CTRL_RST;
      pulse_ms_ff <= dlt_pkg::PULSE_MS_RST;
      bound_ff    <= dlt_pkg::BOUND_RST;
    end else begin
      ctrl_ff     <= nxt_ctrl;
      pulse_ms_ff <= nxt_pulse_ms;
      bound_ff    <= nxt_bound;
    end
  end

  // compare the reading against all four bounds in the strobe cycle
  for (genvar k = 0; k < 4; k++) begin : g_cmp
    if (k % 2 == 0) begin : g_up
      assign hit[k] = $signed(rd_value) >= $signed(bound_ff[k]);
    end else begin : g_lo
      assign hit[k] = $signed(rd_value) <= $signed(bound_ff[k]);
    end
    assign hit_m[k] = hit[k] && ctrl_ff[k / 2];
  end

  assign eval     = rd_valid && (ctrl_ff[dlt_pkg::CTL_EN1] || ctrl_ff[dlt_pkg::CTL_EN2]);
  assign any_now  = |hit_m;
  assign fail_set = {eval && |hit_m[3:2], eval && |hit_m[1:0]};

  assign pif.start  = eval && ctrl_ff[dlt_pkg::CTL_PULSE] && any_now;
  assign pif.stop   = eval && !any_now;
  assign pif.dur_ms = pulse_ms_ff;

  always_comb begin
    nxt_hit = eval ? hit_m : hit_ff;
    for (int t = 0; t < 2; t++) begin
      // a hit in the clearing cycle wins over the clear
      nxt_fail[t] = fail_set[t] || (fail_ff[t] && !(clr[t] ||
                    (ctrl_ff[dlt_pkg::CTL_AUTO1 + t] && idle_entry)));
    end
    if (ctrl_ff[dlt_pkg::CTL_LATCH]) begin
      nxt_master = (eval && any_now) || (master_ff && !trig_restart);
    end else begin
      nxt_master = eval ? any_now : master_ff;
    end
    nxt_pulse_on = pif.start || (pulse_on_ff && !pif.stop && !pif.done);
    lvl = {nxt_master, nxt_hit[2], nxt_hit[3], nxt_hit[0], nxt_hit[1]};
    if (nxt_ctrl[dlt_pkg::CTL_PULSE]) begin
      lvl[3:0] = lvl[3:0] & {4{nxt_pulse_on}};
      if (!nxt_ctrl[dlt_pkg::CTL_LATCH]) lvl[4] = lvl[4] && nxt_pulse_on;
    end
    oe_nxt  = nxt_ctrl[dlt_pkg::CTL_OE];
    pol_nxt = nxt_ctrl[dlt_pkg::CTL_POL];
    nxt_lines = oe_nxt ? (lvl ^ {5{pol_nxt}}) : {5{pol_nxt}};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_ff      <= 4'h0;
      fail_ff     <= 2'h0;
      master_ff   <= 1'b0;
      pulse_on_ff <= 1'b0;
      lines_ff    <= 5'h00;
    end else begin
      hit_ff      <= nxt_hit;
      fail_ff     <= nxt_fail;
      master_ff   <= nxt_master;
      pulse_on_ff <= nxt_pulse_on;
      lines_ff    <= nxt_lines;
    end
  end

  dlt_pulse #(.TICK_CYCLES(TICK_CYCLES)) u_pulse (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pif     (pif.timer)
  );

  // indicators fall over to the second test only while the first is off
  logic       use2;
  logic [1:0] src;
  assign use2     = !ctrl_ff[dlt_pkg::CTL_EN1] && ctrl_ff[dlt_pkg::CTL_EN2];
  assign src      = use2 ? hit_ff[3:2] : hit_ff[1:0];
  assign ind_high = src[0];
  assign ind_low  = src[1];
  assign ind_in   = (ctrl_ff[dlt_pkg::CTL_EN1] || use2) && src == 2'h0;
  assign second_test_inside_message = use2 && src == 2'h0;
  assign out_lines = lines_ff;

  always_comb begin
    status = 32'h00000000;
    status[dlt_pkg::ST_FAIL1]  = fail_ff[0];
    status[dlt_pkg::ST_FAIL2]  = fail_ff[1];
    status[dlt_pkg::ST_MASTER] = master_ff;
    status[dlt_pkg::ST_HIGH]   = ind_high;
    status[dlt_pkg::ST_IN]     = ind_in;
    status[dlt_pkg::ST_LOW]    = ind_low;
    status[dlt_pkg::ST_SECOND] = second_test_inside_message;
    status[dlt_pkg::ST_PULSE]  = pulse_on_ff;
    status[dlt_pkg::ST_LINES +: 5] = lines_ff;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reset_values_a: assert property (disable iff (1'b0) !aresetn |=>
    bound_ff[0] == 33'h000000001 && bound_ff[1] == 33'h1FFFFFFFF && bound_ff[2] == 33'h000000002
    && bound_ff[3] == 33'h1FFFFFFFE && ctrl_ff == 8'h0C && pulse_ms_ff == 27'h0000002)
    else $error("reset values wrong");
  fail_set_a: assert property (eval && ctrl_ff[0] && (hit[0] || hit[1]) |=> fail_ff[0])
    else $error("first fail not set");
  fail_hold_a: assert property (fail_ff[1] && !clr[1] && !(ctrl_ff[3] && idle_entry)
    |=> fail_ff[1]) else $error("second fail lost");
  auto_clear_a: assert property (fail_ff[0] && ctrl_ff[2] && idle_entry && !fail_set[0]
    |=> !fail_ff[0]) else $error("auto clear failed");
  oe_gate_a: assert property (!ctrl_ff[5] |-> out_lines == {5{ctrl_ff[4]}})
    else $error("lines active while disabled");
  pulse_end_a: assert property (pulse_on_ff && rd_valid && (ctrl_ff[0] || ctrl_ff[1])
    && hit_m == 4'h0 |=> !pulse_on_ff) else $error("pulse not ended");
  master_latch_a: assert property (master_ff && ctrl_ff[7] && !trig_restart
    |=> master_ff) else $error("latched master released");
  panel_off_a: assert property (panel_limit_off |=> ctrl_ff[1:0] == 2'h0)
    else $error("panel off ignored");
  line_map_a: assert property (eval && !ctrl_ff[6] && ctrl_ff[5] && !ctrl_ff[4] && hit_m[1]
    |=> out_lines[0] && out_lines[4]) else $error("line one not driven");
  second_ind_a: assert property (use2 && $past(eval) && $past(hit_m[3:2]) == 2'h0
    |-> second_test_inside_message) else $error("second indicator wrong");
  write_resp_a: assert property (do_wr |=> bvalid) else $error("no write response");

  both_fail_c:  cover property (fail_ff == 2'h3);
  pulse_done_c: cover property (pulse_on_ff ##1 !pulse_on_ff && !pif.stop);
  latched_c:    cover property (master_ff && ctrl_ff[7] ##1 trig_restart);
  read_c:       cover property (rvalid && rready && rresp == 2'h0);
endmodule
`default_nettype wire

// *** dlt_pkg.sv ***
// dlt_pkg: register map, field positions, reset values and timing of the dual limit checker
// assumes a 20 MHz aclk and a 32-bit axi4-lite register bus
package dlt_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CLEAR  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PULSE  = 8'h0C;
  localparam logic [7:0] OFS_BOUND  = 8'h10;
  localparam logic [7:0] OFS_BLAST  = 8'h2C;
  localparam logic [7:0] OFS_EVENT  = 8'h30;

  // control field positions
  localparam int CTL_EN1   = 0;
  localparam int CTL_EN2   = 1;
  localparam int CTL_AUTO1 = 2;
  localparam int CTL_AUTO2 = 3;
  localparam int CTL_POL   = 4;
  localparam int CTL_OE    = 5;
  localparam int CTL_PULSE = 6;
  localparam int CTL_LATCH = 7;
  localparam logic [7:0] CTRL_RST = 8'h0C;

  // status field positions
  localparam int ST_FAIL1  = 0;
  localparam int ST_FAIL2  = 1;
  localparam int ST_MASTER = 2;
  localparam int ST_HIGH   = 3;
  localparam int ST_IN     = 4;
  localparam int ST_LOW    = 5;
  localparam int ST_SECOND = 6;
  localparam int ST_PULSE  = 7;
  localparam int ST_LINES  = 8;

  // bounds: index 0 upper first, 1 lower first, 2 upper second, 3 lower second
  localparam int BW = 33;
  localparam logic [BW-1:0] BOUND_MAX = 33'h0FFFFFFFF;
  localparam logic [BW-1:0] BOUND_MIN = 33'h100000001;
  localparam logic [BW-1:0] BOUND_RST [4] = '{33'h000000001, 33'h1FFFFFFFF,
                                             33'h000000002, 33'h1FFFFFFFE};

  // pulse duration in milliseconds
  localparam int PW = 27;
  localparam logic [PW-1:0] PULSE_MS_MIN = 27'h0000001;
  localparam logic [PW-1:0] PULSE_MS_MAX = 27'h5F5E0FF;
  localparam logic [PW-1:0] PULSE_MS_RST = 27'h0000002;

  // timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int MS_TICK_NS     = 1000000;
  localparam int MS_TICK_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** dlt_pulse_if.sv ***
// dlt_pulse_if: start/stop/done between the checker and its pulse timer
// assumes both ends run on aclk
`timescale 1ns/1ps
`default_nettype none
interface dlt_pulse_if;
  logic                   start;
  logic                   stop;
  logic [dlt_pkg::PW-1:0] dur_ms;
  logic                   done;
  modport timer (input start, input stop, input dur_ms, output done);
  modport ctrl  (output start, output stop, output dur_ms, input done);
endinterface
`default_nettype wire

// *** dlt_pulse.sv ***
// dlt_pulse: millisecond tick divider and pulse length counter
// assumes dur_ms is never zero and start/stop are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module dlt_pulse #(
  parameter int TICK_CYCLES = dlt_pkg::MS_TICK_CYCLES
) (
  // clock and reset
  input wire logic   aclk,
  input wire logic   aresetn,
  // control
  dlt_pulse_if.timer pif
);
  localparam int DW = $clog2(TICK_CYCLES + 1);
  localparam logic [DW-1:0] TLAST = DW'(TICK_CYCLES - 1);

  logic                   run_ff;
  logic                   nxt_run;
  logic [dlt_pkg::PW-1:0] cnt_ff;
  logic [dlt_pkg::PW-1:0] nxt_cnt;
  logic [DW-1:0]          div_ff;
  logic [DW-1:0]          nxt_div;
  logic                   tick;

  assign tick     = run_ff && (div_ff == TLAST);
  assign pif.done = tick && (cnt_ff == dlt_pkg::PULSE_MS_MIN);

  always_comb begin
    nxt_run = run_ff;
    nxt_cnt = cnt_ff;
    nxt_div = div_ff;
    if (pif.start) begin
      // a new failing reading restarts the full duration
      nxt_run = 1'b1;
      nxt_cnt = pif.dur_ms;
      nxt_div = '0;
    end else if (pif.stop) begin
      nxt_run = 1'b0;
    end else if (tick) begin
      nxt_div = '0;
      nxt_cnt = cnt_ff - dlt_pkg::PULSE_MS_MIN;
      nxt_run = !pif.done;
    end else if (run_ff) begin
      nxt_div = div_ff + DW'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_ff <= 1'b0;
      cnt_ff <= '0;
      div_ff <= '0;
    end else begin
      run_ff <= nxt_run;
      cnt_ff <= nxt_cnt;
      div_ff <= nxt_div;
    end
  end
endmodule
`default_nettype wire

// *** dlt_handler.sv ***
// dlt_handler: component handler model on the five output lines
// assumes the bench tells it the programmed polarity
`timescale 1ns/1ps
`default_nettype none
module dlt_handler (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // output lines
  input  wire logic [4:0]  lines,
  input  wire logic        active_low,
  // decoded view
  output logic      [4:0]  hit,
  output logic      [15:0] width
);
  logic        prev_ff;
  logic [15:0] width_ff;
  // open collector with pull ups: asserted is the sensed level, not the raw bit
  assign hit   = active_low ? ~lines : lines;
  assign width = width_ff;
  // length of the last pulse on line 2, in whole clock cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_ff  <= 1'h0;
      width_ff <= 16'h0000;
    end else begin
      prev_ff <= hit[1];
      if (hit[1]) begin
        width_ff <= (prev_ff ? width_ff : 16'h0000) + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb_dual_limit_test_digital_outputs.sv ***
// tb_dual_limit_test_digital_outputs: self-checking bench for dlt_top
// assumes the handler model on the lines and a shortened ms tick
`timescale 1ns/1ps
`default_nettype none
module tb_dual_limit_test_digital_outputs;
  localparam int TK = 4;
  localparam logic [7:0] RA [10] = '{8'h00, 8'h0C, 8'h10, 8'h14, 8'h18,
                                     8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C};
  localparam logic [31:0] RV [10] = '{32'h0000000C, 32'h2, 32'h1, 32'h0,
                                      32'hFFFFFFFF, 32'h1, 32'h2, 32'h0, 32'hFFFFFFFE, 32'h1};
  logic        aclk = 1'h0, aresetn = 1'h0, act_low = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, rdata, rdat;
  logic [3:0]  wstrb = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, brsp, rrsp;
  logic        rd_valid = 1'h0, idle_entry = 1'h0, trig_restart = 1'h0, panel_limit_off = 1'h0;
  logic [32:0] rd_value = 33'h0;
  logic [4:0]  out_lines, hit;
  logic        ind_high, ind_in, ind_low, second_test_inside_message;
  logic [15:0] width;
  int          fails = 0, comparisons = 0;

  always #25 aclk = ~aclk;

  dlt_top #(.TICK_CYCLES(TK)) u_dlt_top (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .rd_valid, .rd_value, .idle_entry,
    .trig_restart, .panel_limit_off, .out_lines, .ind_high, .ind_in, .ind_low,
    .second_test_inside_message);
  dlt_handler u_dlt_handler (.aclk, .aresetn, .lines(out_lines), .active_low(act_low),
    .hit, .width);

  task summarize;
    $display("counts: comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task tmo;
    fails++;
    $display("[FAIL] wait expected answer seen none");
    summarize;
  endtask

  // handshake ready is sampled at the falling edge, acted on at the rising one
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, bv;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    n = 0;
    bv = 1'h0;
    while (!bv) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      bv = bvalid;
      brsp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (++n > 50) tmo();
    end
    bready <= 1'h0;
  endtask

  task rd(input logic [7:0] a);
    int n;
    logic ta, rv;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    n = 0;
    rv = 1'h0;
    while (!rv) begin
      @(negedge aclk);
      ta = arvalid && arready;
      rv = rvalid;
      rdat = rdata;
      rrsp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
      if (++n > 50) tmo();
    end
    rready <= 1'h0;
  endtask

  task rdg(input logic [32:0] v);
    @(posedge aclk);
    rd_valid <= 1'h1;
    rd_value <= v;
    @(posedge aclk);
    rd_valid <= 1'h0;
    @(negedge aclk);
  endtask

  // k: 0 idle entry, 1 trigger restart, 2 panel limits off
  task strobe(input int k);
    @(posedge aclk);
    idle_entry <= (k == 0);
    trig_restart <= (k == 1);
    panel_limit_off <= (k == 2);
    @(posedge aclk);
    {idle_entry, trig_restart, panel_limit_off} <= 3'h0;
    @(negedge aclk);
  endtask

  task chst(input string nm, input int b, input logic e);
    rd(dlt_pkg::OFS_STATUS);
    chk(nm, e, rdat[b]);
  endtask

  task t_reset;
    for (int i = 0; i < 10; i++) begin
      rd(RA[i]);
      chk("reset value", RV[i], rdat);
    end
    chk("lines after reset", 5'h00, out_lines);
    $display("test reset done");
  endtask

  task t_fail;
    wr(dlt_pkg::OFS_CTRL, 32'h2D);
    rdg(33'h5);
    chk("lines upper first", 5'h12, out_lines);
    rd(dlt_pkg::OFS_EVENT);
    chk("event upper first", 32'h1, rdat);
    chst("fail first", 0, 1'h1);
    rdg(33'h0);
    chk("lines in limits", 5'h00, out_lines);
    chk("in indicator", 1'h1, ind_in);
    chst("fail held", 0, 1'h1);
    rdg(33'h1FFFFFFFF);
    chk("lines lower first", 5'h11, out_lines);
    chk("low indicator", 1'h1, ind_low);
    $display("test fail done");
  endtask

  task t_clear;
    strobe(0);
    chst("auto clear", 0, 1'h0);
    rdg(33'h7);
    wr(dlt_pkg::OFS_CTRL, 32'h29);
    strobe(0);
    chst("no auto clear", 0, 1'h1);
    wr(dlt_pkg::OFS_CLEAR, 32'h1);
    chst("clear command", 0, 1'h0);
    $display("test clear done");
  endtask

  task t_pol;
    wr(dlt_pkg::OFS_CTRL, 32'h1D);
    act_low <= 1'h1;
    rdg(33'h5);
    chk("lines disabled", 5'h1F, out_lines);
    wr(dlt_pkg::OFS_CTRL, 32'h3D);
    rdg(33'h5);
    chk("lines active low", 5'h0D, out_lines);
    chk("handler view", 5'h12, hit);
    wr(dlt_pkg::OFS_CTRL, 32'h2D);
    act_low <= 1'h0;
    $display("test polarity done");
  endtask

  task t_second;
    // the polarity test left fail one set; idle entry clears it first
    strobe(0);
    wr(dlt_pkg::OFS_CTRL, 32'h2E);
    rdg(33'h0);
    chk("second inside", 1'h1, second_test_inside_message);
    rdg(33'h2);
    chk("high indicator", 1'h1, ind_high);
    chk("lines second", 5'h18, out_lines);
    chst("fail first off", 0, 1'h0);
    chst("fail second", 1, 1'h1);
    wr(dlt_pkg::OFS_CTRL, 32'h2F);
    strobe(2);
    rd(dlt_pkg::OFS_CTRL);
    chk("panel off", 32'h2C, rdat);
    $display("test second done");
  endtask

  task t_pulse;
    int n;
    wr(dlt_pkg::OFS_PULSE, 32'h0);
    rd(dlt_pkg::OFS_PULSE);
    chk("pulse clamp", 32'h1, rdat);
    wr(dlt_pkg::OFS_PULSE, 32'h2);
    wr(dlt_pkg::OFS_CTRL, 32'h6D);
    rdg(33'h5);
    chk("pulse on", 1'h1, out_lines[1]);
    for (n = 0; out_lines[1] === 1'h1 && n < 50; n++) @(negedge aclk);
    if (n >= 50) tmo();
    chk("pulse width", 2 * TK, width);
    rdg(33'h5);
    rdg(33'h0);
    chk("pulse cut", 1'h0, out_lines[1]);
    chst("pulse stopped", dlt_pkg::ST_PULSE, 1'h0);
    wr(dlt_pkg::OFS_CTRL, 32'hAD);
    rdg(33'h5);
    rdg(33'h0);
    chk("master latched", 1'h1, out_lines[4]);
    strobe(1);
    chk("master released", 1'h0, out_lines[4]);
    $display("test pulse done");
  endtask

  task t_bound;
    wr(8'h14, 32'h1);
    wr(8'h10, 32'h0);
    rd(8'h10);
    chk("bound clamp low word", 32'h1, rdat);
    rd(8'h14);
    chk("bound clamp sign", 32'h1, rdat);
    $display("test bound done");
  endtask

  task t_err;
    wr(8'h40, 32'h1);
    chk("write resp", dlt_pkg::RESP_SLVERR, brsp);
    rd(8'h40);
    chk("read resp", dlt_pkg::RESP_SLVERR, rrsp);
    chk("read data", 32'h0, rdat);
    $display("test unmapped done");
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_fail;
    t_clear;
    t_pol;
    t_second;
    t_pulse;
    t_bound;
    t_err;
    summarize;
  end
endmodule
`default_nettype wire
